// ==== rtl/smr_defs.vh ====
// offsets, codes and reset values for the socket mode register bank
`ifndef SMR_DEFS_VH
`define SMR_DEFS_VH
`define SMR_OFF_MODE      16'h0000
`define SMR_RST_MODE      8'h00
`define SMR_CMD_OPEN      8'h01
`define SMR_PROTO_CLOSED  4'h0
`define SMR_PROTO_TCP     4'h1
`define SMR_PROTO_UDP     4'h2
`define SMR_PROTO_RAW     4'h4
`define SMR_BIT_OPT7      7
`define SMR_BIT_OPT6      6
`define SMR_BIT_OPT5      5
`define SMR_BIT_OPT4      4
`define SMR_PROTO_MSB     3
`define SMR_PROTO_LSB     0
`endif

// ==== rtl/smr_mem.v ====
// eight-entry register storage with registered read port
`timescale 1ns/1ns
module smr_mem #(
    parameter N_SOCK = 8,
    parameter SEL_W  = 3,
    parameter DATA_W = 8
) (
    input  wire              clk_i,
    input  wire              rstn_i,
    input  wire              we_i,
    input  wire [SEL_W-1:0]  wsel_i,
    input  wire [DATA_W-1:0] wdata_i,
    input  wire [SEL_W-1:0]  rsel_i,
    output reg  [DATA_W-1:0] rdata_o,
    output wire [N_SOCK*DATA_W-1:0] all_o
);
    reg [DATA_W-1:0] mem_r [0:N_SOCK-1];
    genvar g;
    generate
        for (g = 0; g < N_SOCK; g = g + 1) begin : g_ent
            always @(posedge clk_i) begin
                if (!rstn_i) begin
                    mem_r[g] <= {DATA_W{1'b0}};
                end else if (we_i && wsel_i == g) begin
                    mem_r[g] <= wdata_i;
                end
            end
            assign all_o[g*DATA_W +: DATA_W] = mem_r[g];
        end
    endgenerate
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= {DATA_W{1'b0}};
        end else begin
            rdata_o <= mem_r[rsel_i];
        end
    end
endmodule // smr_mem

// ==== rtl/smr_socket_mode.v ====
// per-socket mode registers and decoded protocol and option enables
`timescale 1ns/1ns
`include "smr_defs.vh"
// What this block does
// - each socket has an 8-bit read/write mode register at offset zero, reset to 0x00.
// - eight register copies exist, picked by the 3-bit socket select field.
// - bits 3..0 pick the protocol: 0001 TCP, 0010 UDP, 0100 raw frame, 0000 closed.
// - in UDP mode bit 7 enables multicast reception.
// - in raw frame mode bit 7 limits reception to broadcast and own-MAC frames.
// - bit 6 drops received broadcasts in UDP and raw frame mode.
// - in TCP mode bit 5 sends ACK at once, else after the retry interval.
// - in multicast UDP bit 5 picks IGMP version 1 when set, version 2 when clear.
// - in raw frame mode bit 5 rejects frames with a multicast destination MAC.
// - in multicast UDP bit 4 rejects received unicast packets.
// - in raw frame mode bit 4 rejects received IPv6 packets.
// - immediate ACK acts only while the protocol is TCP.
// - the open command brings the socket up in the protocol its register selects.
module smr_socket_mode #(
    parameter N_SOCK = 8,
    parameter SEL_W  = 3
) (
    input  wire              clk_i,
    input  wire              rstn_i,
    input  wire              wr_i,
    input  wire              rd_i,
    input  wire [15:0]       addr_i,
    input  wire [SEL_W-1:0]  socket_select_i,
    input  wire [7:0]        wdata_i,
    input  wire              cmd_valid_i,
    input  wire [SEL_W-1:0]  cmd_sel_i,
    input  wire [7:0]        socket_command_i,
    output reg  [7:0]        rdata_o,
    output reg               rvalid_o,
    output reg  [N_SOCK-1:0] open_tcp_o,
    output reg  [N_SOCK-1:0] open_udp_o,
    output reg  [N_SOCK-1:0] open_raw_o,
    output reg  [N_SOCK-1:0] multicast_en_o,
    output reg  [N_SOCK-1:0] mac_filter_enable_o,
    output reg  [N_SOCK-1:0] broadcast_block_o,
    output reg  [N_SOCK-1:0] immediate_ack_o,
    output reg  [N_SOCK-1:0] igmp_version_select_o,
    output reg  [N_SOCK-1:0] multicast_mac_block_o,
    output reg  [N_SOCK-1:0] unicast_block_o,
    output reg  [N_SOCK-1:0] ipv6_block_o
);
    wire             hit;
    wire [7:0]       mem_rdata;
    wire [N_SOCK*8-1:0] all_modes;
    reg              rd_d_r;
    reg              hit_d_r;

    assign hit = (addr_i == `SMR_OFF_MODE);

    smr_mem #(
        .N_SOCK (N_SOCK),
        .SEL_W  (SEL_W),
        .DATA_W (8)
    ) u_mem (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (wr_i & hit),
        .wsel_i  (socket_select_i),
        .wdata_i (wdata_i),
        .rsel_i  (socket_select_i),
        .rdata_o (mem_rdata),
        .all_o   (all_modes)
    );

    // read answers two cycles after the request, zero when unmapped
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_d_r   <= 1'b0;
            hit_d_r  <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o  <= 8'h00;
        end else begin
            rd_d_r   <= rd_i;
            hit_d_r  <= hit;
            rvalid_o <= rd_d_r;
            rdata_o  <= hit_d_r ? mem_rdata : 8'h00;
        end
    end

    genvar s;
    generate
        for (s = 0; s < N_SOCK; s = s + 1) begin : g_sock
            wire [7:0] m    = all_modes[s*8 +: 8];
            wire [3:0] pr   = m[`SMR_PROTO_MSB:`SMR_PROTO_LSB];
            wire       tcp  = (pr == `SMR_PROTO_TCP);
            wire       udp  = (pr == `SMR_PROTO_UDP);
            wire       raw  = (pr == `SMR_PROTO_RAW);
            wire       mc   = udp & m[`SMR_BIT_OPT7];
            wire       open = cmd_valid_i && cmd_sel_i == s
                              && socket_command_i == `SMR_CMD_OPEN;
            always @(posedge clk_i) begin
                if (!rstn_i) begin
                    open_tcp_o[s]            <= 1'b0;
                    open_udp_o[s]            <= 1'b0;
                    open_raw_o[s]            <= 1'b0;
                    multicast_en_o[s]        <= 1'b0;
                    mac_filter_enable_o[s]   <= 1'b0;
                    broadcast_block_o[s]     <= 1'b0;
                    immediate_ack_o[s]       <= 1'b0;
                    igmp_version_select_o[s] <= 1'b0;
                    multicast_mac_block_o[s] <= 1'b0;
                    unicast_block_o[s]       <= 1'b0;
                    ipv6_block_o[s]          <= 1'b0;
                end else begin
                    // open pulse per selected protocol, high one cycle after each cycle the open command is valid
                    open_tcp_o[s] <= open & tcp;
                    open_udp_o[s] <= open & udp;
                    open_raw_o[s] <= open & raw;
                    multicast_en_o[s] <= mc;
                    mac_filter_enable_o[s] <=
                        raw & m[`SMR_BIT_OPT7];
                    broadcast_block_o[s] <=
                        (udp | raw) & m[`SMR_BIT_OPT6];
                    immediate_ack_o[s] <=
                        tcp & m[`SMR_BIT_OPT5];
                    igmp_version_select_o[s] <=
                        mc & m[`SMR_BIT_OPT5];
                    multicast_mac_block_o[s] <=
                        raw & m[`SMR_BIT_OPT5];
                    unicast_block_o[s] <=
                        mc & m[`SMR_BIT_OPT4];
                    ipv6_block_o[s] <=
                        raw & m[`SMR_BIT_OPT4];
                end
            end
        end
    endgenerate
endmodule // smr_socket_mode

// ==== tb/smr_host.sv ====
// host model driving register and command strobes
`timescale 1ns/1ns
module smr_host (
    input  wire clk_i,
    output logic wr_o, rd_o, cmd_o,
    output logic [15:0] addr_o,
    output logic [2:0] sel_o,
    output logic [7:0] wdata_o, code_o);
    logic [7:0] qr[$], sh[8] = '{default: 8'h00};
    logic [23:0] qo[$];
    initial {wr_o, rd_o, cmd_o, addr_o, sel_o, wdata_o, code_o} = '0;
    task acc(input logic [2:0] f, input logic [15:0] a,
             input logic [2:0] s, input logic [7:0] d, k);
        @(negedge clk_i) {wr_o, rd_o, cmd_o, addr_o, sel_o, wdata_o, code_o} =
            {f, a, s, d, k};
        @(negedge clk_i) {wr_o, rd_o, cmd_o} = 3'b000;
    endtask
    task wr(input logic [2:0] s, input logic [7:0] d);
        sh[s] = d;
        acc(3'b100, 16'h0000, s, d, 8'h00);
    endtask
    task rd(input logic [2:0] s, input logic [15:0] a);
        qr.push_back(a == 0 ? sh[s] : 8'h00);
        acc(3'b010, a, s, 8'h00, 8'h00);
    endtask
    task opn(input logic [2:0] s, input logic [7:0] k);
        logic [23:0] e;
        // layout matches {open_tcp, open_udp, open_raw}, bit s per socket
        e = {sh[s][3:0] == 4'h1 ? 8'h01 << s : 8'h00,
             sh[s][3:0] == 4'h2 ? 8'h01 << s : 8'h00,
             sh[s][3:0] == 4'h4 ? 8'h01 << s : 8'h00};
        // group address and port live outside this block
        if (k == 8'h01 && e != 0) qo.push_back(e);
        acc(3'b001, 16'h0000, s, 8'h00, k);
    endtask
endmodule // smr_host

// ==== tb/smr_socket_mode_props.sv ====
// assertions on the socket mode register ports
`timescale 1ns/1ns
module smr_props #(parameter N_SOCK = 8, parameter SEL_W = 3) (
input wire clk_i, rstn_i, wr_i, rd_i, cmd_valid_i, rvalid_o,
input wire [15:0] addr_i,
input wire [SEL_W-1:0] socket_select_i,
input wire [7:0] wdata_i, socket_command_i, rdata_o,
input wire [N_SOCK-1:0] open_tcp_o, open_udp_o, open_raw_o, multicast_en_o,
input wire [N_SOCK-1:0] mac_filter_enable_o, immediate_ack_o, ipv6_block_o,
input wire [N_SOCK-1:0] igmp_version_select_o, unicast_block_o,
input wire [N_SOCK-1:0] broadcast_block_o, multicast_mac_block_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!rstn_i);
wire hit = wr_i && addr_i == 16'h0000;
AST_RD_LAT: assert property (rd_i |-> ##2 rvalid_o)
    else $error("read not answered");
AST_RD_ONE: assert property (!rd_i |-> ##2 !rvalid_o)
    else $error("answer without read");
AST_UNMAP: assert property (rd_i && addr_i != 0 |-> ##2 rdata_o == 0)
    else $error("unmapped read not zero");
AST_IPV6: assert property (hit |-> ##2 ipv6_block_o[$past(socket_select_i,2)]
    == (($past(wdata_i,2) & 8'h1F) == 8'h14)) else $error("ipv6 block wrong");
AST_NOACK: assert property (hit |-> ##2 immediate_ack_o[$past(socket_select_i,2)]
    == (($past(wdata_i,2) & 8'h2F) == 8'h21)) else $error("ack option wrong");
AST_BCAST: assert property (hit |-> ##2 broadcast_block_o[$past(socket_select_i,2)]
    == ($past(wdata_i[6],2) && ($past(wdata_i[3:0],2) == 4'h2
    || $past(wdata_i[3:0],2) == 4'h4))) else $error("broadcast block wrong");
AST_MMB: assert property (hit |-> ##2 multicast_mac_block_o[$past(socket_select_i,2)]
    == (($past(wdata_i,2) & 8'h2F) == 8'h24)) else $error("mcast mac block wrong");
AST_MCAST: assert property (((igmp_version_select_o | unicast_block_o)
    & ~multicast_en_o) == 0) else $error("multicast option leak");
AST_TCPONLY: assert property ((immediate_ack_o & (mac_filter_enable_o
    | multicast_en_o)) == 0) else $error("ack option outside tcp");
AST_OPEN: assert property (|{open_tcp_o, open_udp_o, open_raw_o} |->
    $past(cmd_valid_i && socket_command_i == 8'h01)) else $error("open w/o cmd");
endmodule // smr_props
bind smr_socket_mode smr_props #(.N_SOCK(N_SOCK), .SEL_W(SEL_W)) smr_props_i (.*);

// ==== tb/smr_socket_mode_test.sv ====
// self-checking bench for the socket mode register bank
`timescale 1ns/1ns
module smr_socket_mode_test;
    logic clk_i = 0, rstn_i = 0, wr, rd, cmd, rv;
    logic [15:0] ad;
    logic [2:0] sl;
    logic [7:0] wd, cd, rdo, t, u, r;
    logic [3:0] p;
    logic [3:0] pr[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [31:0] rs = 32'd95124, v;
    int bad_count = 0, n_tests = 0;
    initial forever #5 clk_i = ~clk_i;
    function logic [31:0] xs();
        rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5; return rs;
    endfunction
    smr_host smr_host_i (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .cmd_o(cmd),
        .addr_o(ad), .sel_o(sl), .wdata_o(wd), .code_o(cd));
    smr_socket_mode smr_socket_mode_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .wr_i(wr), .rd_i(rd), .addr_i(ad), .socket_select_i(sl),
        .wdata_i(wd), .cmd_valid_i(cmd), .cmd_sel_i(sl),
        .socket_command_i(cd), .rdata_o(rdo), .rvalid_o(rv),
        .open_tcp_o(t), .open_udp_o(u), .open_raw_o(r), .multicast_en_o(),
        .mac_filter_enable_o(), .broadcast_block_o(), .immediate_ack_o(),
        .igmp_version_select_o(), .multicast_mac_block_o(),
        .unicast_block_o(), .ipv6_block_o());
    task chk(input logic [23:0] e, g);
        n_tests++;
        if (e !== g) begin
            bad_count++;
            $display("mismatch %0t exp %h got %h", $time, e, g);
        end
    endtask
    always @(posedge clk_i) begin
        if (rv === 1'b1) chk(smr_host_i.qr.pop_front(), rdo);
        if (|{t, u, r} !== 1'b0) chk(smr_host_i.qo.pop_front(), {t, u, r});
    end
    task summarize();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000 bad_count++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i) rstn_i = 1;
        for (int s = 0; s < 8; s++) smr_host_i.rd(s, 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 80; i++) begin
            v = xs();
            p = pr[v[10:8] % 5];
            if (p == 4'h4 && v[13:11] != 3'h0) p = 4'h0;
            if (p == 4'h4 && v[24]) v[7] = 1'b1;
            smr_host_i.wr(v[13:11], {v[7:4], p});
            smr_host_i.rd(v[13:11], v[14] ? 16'h0000 : v[31:16]);
            smr_host_i.opn(v[13:11], v[15] ? 8'h01 : v[23:16]);
        end
        repeat (4) @(posedge clk_i);
        $display("random access done");
        summarize();
    end
endmodule // smr_socket_mode_test
